// >>> common/secl_defs.svh
// register indexes, field positions, reset values and timing counts
`ifndef SECL_DEFS_SVH
`define SECL_DEFS_SVH
// register indexes; byte address is four times the index
`define SECL_IDX_RAM_LOCK 8'hf0
`define SECL_IDX_EE_LOCK 8'hf1
`define SECL_IDX_PTR 8'hf2
`define SECL_IDX_WBYTE 8'hf3
`define SECL_IDX_WPROG 8'hf4
`define SECL_IDX_RBYTE 8'hf5
`define SECL_IDX_RSTAT 8'hf6
`define SECL_IDX_IRQ_STAT 8'hf8
`define SECL_IDX_IRQ_MASK 8'hf9
// field positions
`define SECL_BANK_BIT 7
`define SECL_WIDE_BIT 4
`define SECL_NOPF_BIT 7
`define SECL_IRQ_WDONE 0
`define SECL_IRQ_RVALID 1
`define SECL_IRQ_LOCKED 2
// reset values
`define SECL_PTR_RST 8'h00
`define SECL_WPROG_RST 2'h3
// serial opcodes and address lengths
`define SECL_OP_READ 2'h2
`define SECL_OP_WRITE 2'h1
`define SECL_OP_EWEN 2'h0
`define SECL_EWEN_ADDR 8'hff
`define SECL_ABITS_NARROW 6
`define SECL_ABITS_WIDE 8
// timing
`define SECL_CLK_NS 10
`define SECL_SK_HALF_NS 500
`define SECL_SK_HALF_CYC ((`SECL_SK_HALF_NS + `SECL_CLK_NS - 1) / `SECL_CLK_NS)
`define SECL_WRITE_TMO_NS 10000000
`define SECL_WRITE_TMO_CYC (`SECL_WRITE_TMO_NS / `SECL_CLK_NS)
`endif

// >>> common/secl_pkg.sv
// types shared by the eeprom access and cmos lock logic
`default_nettype none
package secl_pkg;
  typedef enum logic [1:0] {CMD_READ, CMD_WRITE, CMD_EWEN} secl_cmd_kind_t;
  typedef struct packed {
    secl_cmd_kind_t kind;
    logic wide;
    logic [7:0] addr;
    logic [15:0] data;
  } secl_cmd_t;
  typedef struct packed {
    logic done;
    logic [15:0] data;
  } secl_rsp_t;
  typedef struct packed {
    logic cs;
    logic sk;
    logic di;
  } secl_pins_t;
  typedef enum logic [1:0] {ENG_IDLE, ENG_SHIFT, ENG_GAP, ENG_POLL} secl_eng_phase_t;
  typedef struct packed {
    secl_eng_phase_t phase;
    logic [19:0] div;
    logic [5:0] bits;
    logic [26:0] shOut;
    logic [15:0] shIn;
    logic isWrite;
    logic cs;
    logic sk;
    logic done;
  } secl_eng_t;
  typedef enum logic [1:0] {PH_IDLE, PH_FETCH, PH_EWEN, PH_WRITE} secl_phase_t;
  typedef struct packed {
    secl_phase_t phase;
    logic [3:0] ramLock;
    logic ramUpper;
    logic [3:0] eeLock;
    logic eeWide;
    logic [7:0] ptr;
    logic [1:0] wrStat;
    logic noPrefetch;
    logic [7:0] wrLow;
    logic [15:0] wrWord;
    logic [7:0] wrAddr;
    logic wrPending;
    logic fetchPending;
    logic [15:0] rdWord;
    logic rdValid;
    logic rdHigh;
    logic cmdValid;
    secl_cmd_t cmd;
    logic [2:0] irqStat;
    logic [2:0] irqMask;
    logic dpValid;
    logic dpWrite;
    logic [7:0] dpIdx;
    logic rdReady;
    logic [7:0] rdByte;
  } secl_state_t;
endpackage
`default_nettype wire

// >>> logic/secl_serial_engine.sv
// bit-serial engine that runs one command on the serial eeprom pins
`include "secl_defs.svh"
`default_nettype none
module secl_serial_engine #(
  parameter int SK_HALF = `SECL_SK_HALF_CYC, // cycles per half sk period
  parameter int POLL_MAX = `SECL_WRITE_TMO_CYC // longest wait for programming
) (
  input wire logic clock, // system clock
  input wire logic reset_n, // synchronous reset
  input wire logic cmdValid, // one-cycle start pulse, only while idle
  input wire secl_pkg::secl_cmd_t cmd, // command to run
  output var secl_pkg::secl_rsp_t rsp, // done pulse and read word
  output var secl_pkg::secl_pins_t pins, // select, clock, data to memory
  input wire logic eeDo // data from memory
);
  secl_pkg::secl_eng_t state_reg, state_next;
  logic [26:0] frame;
  logic [5:0] nBits;

  // start bit, opcode, address, data, left aligned
  always_comb begin
    logic [1:0] op;
    op = `SECL_OP_EWEN;
    if (cmd.kind == secl_pkg::CMD_READ) begin
      op = `SECL_OP_READ;
    end else if (cmd.kind == secl_pkg::CMD_WRITE) begin
      op = `SECL_OP_WRITE;
    end
    if (cmd.wide) begin
      frame = {1'b1, op, cmd.addr, cmd.data};
      nBits = 6'(3 + `SECL_ABITS_WIDE);
    end else begin
      frame = {1'b1, op, cmd.addr[5:0], cmd.data, 2'b00};
      nBits = 6'(3 + `SECL_ABITS_NARROW);
    end
    if (cmd.kind == secl_pkg::CMD_WRITE) begin
      nBits = nBits + 6'd16;
    end else if (cmd.kind == secl_pkg::CMD_READ) begin
      nBits = nBits + 6'd17; // dummy zero then sixteen data bits
    end
  end

  // sequencing of one frame
  always_comb begin
    state_next = state_reg;
    state_next.done = 1'b0;
    case (state_reg.phase)
      secl_pkg::ENG_IDLE: begin
        if (cmdValid) begin
          state_next.phase = secl_pkg::ENG_SHIFT;
          state_next.cs = 1'b1;
          state_next.sk = 1'b0;
          state_next.div = 20'h00000;
          state_next.shOut = frame;
          state_next.bits = nBits;
          state_next.isWrite = (cmd.kind == secl_pkg::CMD_WRITE);
        end
      end
      secl_pkg::ENG_SHIFT: begin
        if (state_reg.div == 20'(SK_HALF - 1)) begin
          state_next.div = 20'h00000;
          if (!state_reg.sk) begin
            state_next.sk = 1'b1;
            state_next.shIn = {state_reg.shIn[14:0], eeDo};
          end else begin
            state_next.sk = 1'b0;
            state_next.shOut = {state_reg.shOut[25:0], 1'b0};
            state_next.bits = state_reg.bits - 6'd1;
            if (state_reg.bits == 6'd1) begin
              state_next.cs = 1'b0;
              state_next.phase = state_reg.isWrite ? secl_pkg::ENG_GAP : secl_pkg::ENG_IDLE;
              state_next.done = !state_reg.isWrite;
            end
          end
        end else begin
          state_next.div = state_reg.div + 20'h00001;
        end
      end
      secl_pkg::ENG_GAP: begin
        if (state_reg.div == 20'(SK_HALF - 1)) begin
          state_next.div = 20'h00000;
          state_next.cs = 1'b1; // reselect to watch the ready level
          state_next.phase = secl_pkg::ENG_POLL;
        end else begin
          state_next.div = state_reg.div + 20'h00001;
        end
      end
      secl_pkg::ENG_POLL: begin
        if (eeDo || state_reg.div == 20'(POLL_MAX - 1)) begin
          state_next.cs = 1'b0;
          state_next.done = 1'b1;
          state_next.div = 20'h00000;
          state_next.phase = secl_pkg::ENG_IDLE;
        end else begin
          state_next.div = state_reg.div + 20'h00001;
        end
      end
      default: begin
        state_next.phase = secl_pkg::ENG_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs straight from flops
  assign rsp.done = state_reg.done;
  assign rsp.data = state_reg.shIn;
  assign pins.cs = state_reg.cs;
  assign pins.sk = state_reg.sk;
  assign pins.di = state_reg.shOut[26];
endmodule
`default_nettype wire

// >>> logic/secl_top.sv
// serial eeprom host access and cmos ram lock and bank control
// Notes on behaviour
// - each of the four low clock mode bits write-protects one 32-byte upper block.
// - clock mode bit 7 picks the upper 128-byte bank, zero the lower one.
// - set lock bits in both mode registers stay set until a hard reset.
// - each of the four low eeprom mode bits locks one 32-word range below 80h.
// - eeprom mode bit 4 picks the large part class and the longer address.
// - the pointer is writable, reads back live and clears on any reset.
// - the pointer steps after each read byte pair and each written byte pair.
// - a word is written as low byte then high byte to the write data register.
// - the first byte clears status bit 0; the second, for an unlocked word, clears bit 1 and starts a write.
// - status 11 means ready and the register resets to 03h.
// - status 10 means low byte held and 00 means programming in progress.
// - with status bit 7 clear a pointer write fetches the addressed word.
// - reading the high byte drops valid, steps the pointer and fetches again.
// - read status bit 0 marks valid read data, otherwise reads are harmless.
`include "secl_defs.svh"
`default_nettype none
module secl_top #(
  parameter int SK_HALF = `SECL_SK_HALF_CYC, // sk half period in cycles
  parameter int WRITE_TMO = `SECL_WRITE_TMO_CYC // programming wait limit
) (
  input wire logic clock, // 100 MHz clock
  input wire logic reset_n, // power-on or hard reset
  input wire logic softReset, // software or bus reset pulse
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write transfer
  input wire logic [2:0] hsize, // transfer size
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic hreadyout, // slave ready
  output logic hresp, // always okay
  output logic [31:0] hrdata, // read data
  output logic irq, // level interrupt
  input wire logic [6:0] cmosIndex, // offset within the cmos bank
  output logic [7:0] cmosAddr, // full cmos ram address
  output logic cmosWriteOk, // write to cmosAddr allowed
  output var secl_pkg::secl_pins_t eePins, // serial eeprom pins
  input wire logic eeDo // serial eeprom data out
);
  secl_pkg::secl_state_t state_reg, state_next;
  secl_pkg::secl_rsp_t rsp;
  logic [7:0] busByte;
  logic busWr;
  logic rdCycle;
  logic addrOk;
  logic locked;
  logic [7:0] rdMux;

  assign busByte = hwdata[7:0];
  assign busWr = state_reg.dpValid && state_reg.dpWrite;
  assign rdCycle = state_reg.dpValid && !state_reg.dpWrite && !state_reg.rdReady;
  assign addrOk = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0) && (hsize == 3'h2);
  assign locked = !state_reg.ptr[7] && state_reg.eeLock[state_reg.ptr[6:5]];

  // read data selection
  always_comb begin
    case (state_reg.dpIdx)
      `SECL_IDX_RAM_LOCK: rdMux = {state_reg.ramUpper, 3'h0, state_reg.ramLock};
      `SECL_IDX_EE_LOCK: rdMux = {3'h0, state_reg.eeWide, state_reg.eeLock};
      `SECL_IDX_PTR: rdMux = state_reg.ptr;
      `SECL_IDX_WPROG: rdMux = {state_reg.noPrefetch, 5'h00, state_reg.wrStat};
      `SECL_IDX_RBYTE: begin
        if (!state_reg.rdValid) begin
          rdMux = 8'h00;
        end else if (state_reg.rdHigh) begin
          rdMux = state_reg.rdWord[15:8];
        end else begin
          rdMux = state_reg.rdWord[7:0];
        end
      end
      `SECL_IDX_RSTAT: rdMux = {7'h00, state_reg.rdValid};
      `SECL_IDX_IRQ_STAT: rdMux = {5'h00, state_reg.irqStat};
      `SECL_IDX_IRQ_MASK: rdMux = {5'h00, state_reg.irqMask};
      default: rdMux = 8'h00;
    endcase
  end

  // next state of the whole block
  always_comb begin
    logic [2:0] ev;
    ev = 3'h0;
    state_next = state_reg;
    state_next.cmdValid = 1'b0;
    // engine sequencing
    case (state_reg.phase)
      secl_pkg::PH_IDLE: begin
        if (state_reg.wrPending) begin
          state_next.cmd.kind = secl_pkg::CMD_EWEN;
          state_next.cmd.addr = `SECL_EWEN_ADDR;
          state_next.cmd.wide = state_reg.eeWide;
          state_next.cmdValid = 1'b1;
          state_next.phase = secl_pkg::PH_EWEN;
        end else if (state_reg.fetchPending) begin
          state_next.cmd.kind = secl_pkg::CMD_READ;
          state_next.cmd.addr = state_reg.ptr;
          state_next.cmd.wide = state_reg.eeWide;
          state_next.cmdValid = 1'b1;
          state_next.fetchPending = 1'b0;
          state_next.phase = secl_pkg::PH_FETCH;
        end
      end
      secl_pkg::PH_FETCH: begin
        if (rsp.done) begin
          state_next.rdWord = rsp.data;
          state_next.rdHigh = 1'b0;
          state_next.phase = secl_pkg::PH_IDLE;
          if (!state_reg.fetchPending) begin
            state_next.rdValid = 1'b1;
            ev[`SECL_IRQ_RVALID] = 1'b1;
          end
        end
      end
      secl_pkg::PH_EWEN: begin
        if (rsp.done) begin
          state_next.cmd.kind = secl_pkg::CMD_WRITE;
          state_next.cmd.addr = state_reg.wrAddr;
          state_next.cmd.data = state_reg.wrWord;
          state_next.cmdValid = 1'b1;
          state_next.phase = secl_pkg::PH_WRITE;
        end
      end
      secl_pkg::PH_WRITE: begin
        if (rsp.done) begin
          state_next.wrStat = `SECL_WPROG_RST;
          state_next.wrPending = 1'b0;
          state_next.phase = secl_pkg::PH_IDLE;
          ev[`SECL_IRQ_WDONE] = 1'b1;
        end
      end
      default: begin
        state_next.phase = secl_pkg::PH_IDLE;
      end
    endcase
    // address phase capture
    if (hready) begin
      state_next.dpValid = hsel && htrans[1];
      state_next.dpWrite = hwrite;
      state_next.dpIdx = addrOk ? haddr[9:2] : 8'h00;
      state_next.rdReady = 1'b0;
    end else if (rdCycle) begin
      state_next.rdReady = 1'b1;
    end
    // register writes in the data phase
    if (busWr) begin
      case (state_reg.dpIdx)
        `SECL_IDX_RAM_LOCK: begin
          state_next.ramLock = state_reg.ramLock | busByte[3:0];
          state_next.ramUpper = busByte[`SECL_BANK_BIT];
        end
        `SECL_IDX_EE_LOCK: begin
          state_next.eeLock = state_reg.eeLock | busByte[3:0];
          state_next.eeWide = busByte[`SECL_WIDE_BIT];
        end
        `SECL_IDX_PTR: begin
          state_next.ptr = busByte;
          if (!state_reg.noPrefetch) begin
            state_next.fetchPending = 1'b1;
            state_next.rdValid = 1'b0;
            state_next.rdHigh = 1'b0;
          end
        end
        `SECL_IDX_WBYTE: begin
          if (state_reg.wrStat == 2'h3) begin
            state_next.wrLow = busByte;
            state_next.wrStat = 2'h2;
          end else if (state_reg.wrStat == 2'h2) begin
            state_next.wrWord = {busByte, state_reg.wrLow};
            state_next.wrAddr = state_reg.ptr;
            state_next.ptr = state_reg.ptr + 8'h01;
            if (locked) begin
              state_next.wrStat = 2'h3;
              ev[`SECL_IRQ_LOCKED] = 1'b1;
            end else begin
              state_next.wrStat = 2'h0;
              state_next.wrPending = 1'b1;
            end
          end
        end
        `SECL_IDX_WPROG: state_next.noPrefetch = busByte[`SECL_NOPF_BIT];
        `SECL_IDX_IRQ_STAT: state_next.irqStat = state_reg.irqStat & ~busByte[2:0];
        `SECL_IDX_IRQ_MASK: state_next.irqMask = busByte[2:0];
        default: state_next.ramUpper = state_next.ramUpper;
      endcase
    end
    // register reads and their side effects
    if (rdCycle) begin
      state_next.rdByte = rdMux;
      if (state_reg.dpIdx == `SECL_IDX_RBYTE && state_reg.rdValid) begin
        state_next.rdHigh = !state_reg.rdHigh;
        if (state_reg.rdHigh) begin
          state_next.rdValid = 1'b0;
          state_next.ptr = state_reg.ptr + 8'h01;
          state_next.fetchPending = 1'b1;
        end
      end
    end
    // sticky events, a set wins over a clear
    state_next.irqStat = state_next.irqStat | ev;
    // software reset leaves locks and mode alone
    if (softReset) begin
      state_next.ptr = `SECL_PTR_RST;
      state_next.wrStat = `SECL_WPROG_RST;
      state_next.noPrefetch = 1'b0;
      state_next.wrPending = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state_reg <= '0;
      state_reg.wrStat <= `SECL_WPROG_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  secl_serial_engine #(
    .SK_HALF(SK_HALF),
    .POLL_MAX(WRITE_TMO)
  ) engine (
    .clock(clock),
    .reset_n(reset_n),
    .cmdValid(state_reg.cmdValid),
    .cmd(state_reg.cmd),
    .rsp(rsp),
    .pins(eePins),
    .eeDo(eeDo)
  );

  // bus answers, one wait state on reads
  assign hreadyout = !rdCycle;
  assign hresp = 1'b0;
  assign hrdata = {24'h000000, state_reg.rdByte};
  assign irq = |(state_reg.irqStat & state_reg.irqMask);
  // cmos bank mapping and block protection
  assign cmosAddr = {state_reg.ramUpper, cmosIndex};
  assign cmosWriteOk = !(state_reg.ramUpper && state_reg.ramLock[cmosIndex[6:5]]);

  default clocking dc @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  a_ram_lock_hold: assert property ($past(reset_n) |->
    (($past(state_reg.ramLock) & ~state_reg.ramLock) == 4'h0))
    else $error("cmos lock bit cleared");
  a_ee_lock_hold: assert property ($past(reset_n) |->
    (($past(state_reg.eeLock) & ~state_reg.eeLock) == 4'h0))
    else $error("eeprom lock bit cleared");
  a_cmos_lock_gate: assert property ((state_reg.ramUpper &&
    state_reg.ramLock[cmosIndex[6:5]]) |-> !cmosWriteOk)
    else $error("locked cmos block writable");
  a_cmos_bank_low: assert property (!state_reg.ramUpper |->
    (cmosWriteOk && !cmosAddr[7]))
    else $error("lower bank mapped wrong");
  a_cmd_size_class: assert property (state_reg.cmdValid |->
    (state_reg.cmd.wide == state_reg.eeWide))
    else $error("address length ignores type bit");
  a_soft_ptr_clear: assert property (softReset |=> state_reg.ptr == 8'h00)
    else $error("pointer not cleared");
  a_soft_status_rdy: assert property (softReset |=> state_reg.wrStat == 2'h3)
    else $error("write status not ready after reset");
  a_first_byte_clr: assert property ((busWr && state_reg.dpIdx == `SECL_IDX_WBYTE &&
    state_reg.wrStat == 2'h3 && !softReset) |=> state_reg.wrStat == 2'h2)
    else $error("first byte did not clear bit 0");
  a_pair_order: assert property ((busWr && state_reg.dpIdx == `SECL_IDX_WBYTE &&
    state_reg.wrStat == 2'h2) |=> state_reg.wrWord == {$past(busByte), $past(state_reg.wrLow)})
    else $error("word bytes in wrong order");
  a_pair_step: assert property ((busWr && state_reg.dpIdx == `SECL_IDX_WBYTE &&
    state_reg.wrStat == 2'h2 && !softReset) |=> state_reg.ptr == $past(state_reg.ptr) + 8'h01)
    else $error("pointer not stepped after write pair");
  a_busy_then_go: assert property ((busWr && state_reg.dpIdx == `SECL_IDX_WBYTE &&
    state_reg.wrStat == 2'h2 && !locked && !softReset && state_reg.phase == secl_pkg::PH_IDLE &&
    !state_reg.fetchPending) |=> state_reg.wrStat == 2'h0 ##[1:3]
    (state_reg.cmdValid && state_reg.cmd.kind == secl_pkg::CMD_EWEN))
    else $error("second byte did not start a write");
  a_locked_drop: assert property ((busWr && state_reg.dpIdx == `SECL_IDX_WBYTE &&
    state_reg.wrStat == 2'h2 && locked && !state_reg.wrPending)
    |=> (state_reg.wrStat == 2'h3 && !state_reg.wrPending))
    else $error("locked write not dropped");
  a_ready_return: assert property ((state_reg.phase == secl_pkg::PH_WRITE &&
    rsp.done) |=> state_reg.wrStat == 2'h3)
    else $error("status not ready after programming");
  a_prefetch_go: assert property ((busWr && state_reg.dpIdx == `SECL_IDX_PTR &&
    !state_reg.noPrefetch && state_reg.phase == secl_pkg::PH_IDLE && !state_reg.wrPending &&
    !softReset) |-> ##2 (state_reg.cmdValid && state_reg.cmd.kind == secl_pkg::CMD_READ))
    else $error("pointer write did not prefetch");
  a_no_prefetch: assert property ((busWr && state_reg.dpIdx == `SECL_IDX_PTR &&
    state_reg.noPrefetch && !state_reg.fetchPending) |=> !state_reg.fetchPending)
    else $error("prefetch despite disable bit");
  a_high_read: assert property ((rdCycle && state_reg.dpIdx == `SECL_IDX_RBYTE &&
    state_reg.rdValid && state_reg.rdHigh && !softReset) |=> (!state_reg.rdValid &&
    state_reg.fetchPending && state_reg.ptr == $past(state_reg.ptr) + 8'h01))
    else $error("high byte read did not refetch");
  a_invalid_read: assert property ((rdCycle && state_reg.dpIdx == `SECL_IDX_RBYTE &&
    !state_reg.rdValid && !softReset) |=> (state_reg.rdByte == 8'h00 &&
    state_reg.ptr == $past(state_reg.ptr)))
    else $error("invalid read had side effects");

  c_write_done: cover property (state_reg.phase == secl_pkg::PH_WRITE && rsp.done);
  c_fetch_done: cover property (state_reg.phase == secl_pkg::PH_FETCH && rsp.done);
  c_locked_write: cover property (busWr && state_reg.dpIdx == `SECL_IDX_WBYTE &&
    state_reg.wrStat == 2'h2 && locked);
  c_high_read: cover property (rdCycle && state_reg.dpIdx == `SECL_IDX_RBYTE &&
    state_reg.rdValid && state_reg.rdHigh);
endmodule
`default_nettype wire

// >>> verif/secl_eeprom_model.sv
// behavioural x16 serial eeprom that answers the block's serial pins
`default_nettype none
module secl_eeprom_model #(
  parameter int BUSY = 30 // programming time in clock cycles
) (
  input wire logic clock, // system clock
  input wire logic wide, // attached part takes eight address bits
  input wire secl_pkg::secl_pins_t pins, // select, clock, data in
  output logic eeDo // data out
);
  logic [15:0] mem [256];
  logic [31:0] sr = 32'h0;
  logic [16:0] sh = 17'h0;
  logic skOld = 1'b0, csOld = 1'b0, drv = 1'b0, ewen = 1'b0, pend = 1'b0, tog = 1'b0;
  int cnt = 0;
  int busy = 0;
  int ab;
  logic [7:0] amask;
  // address length and mask follow the attached part size
  assign ab = wide ? 8 : 6;
  assign amask = wide ? 8'hff : 8'h3f;
  // released output toggles; ready shown only while polled after a write
  assign eeDo = drv ? sh[16] : ((pend && pins.cs) ? (busy == 0) : tog);
  // frame decode on sampled sk edges
  always @(posedge clock) begin
    skOld <= pins.sk;
    csOld <= pins.cs;
    tog <= ~tog;
    if (busy > 0) busy <= busy - 1;
    if (!pins.cs) begin
      cnt <= 0;
      drv <= 1'b0;
      if (csOld) begin
        pend <= 1'b0;
        if (cnt == 3 + ab && sr[ab+1 -: 2] == 2'h0 && sr[ab-1 -: 2] == 2'h3)
          ewen <= 1'b1;
        if (cnt == 3 + ab + 16 && sr[ab+17 -: 2] == 2'h1 && ewen) begin
          mem[sr[23:16] & amask] <= sr[15:0];
          pend <= 1'b1;
          busy <= BUSY;
        end
      end
    end else if (pins.sk && !skOld) begin
      sr <= {sr[30:0], pins.di};
      cnt <= cnt + 1;
    end else if (!pins.sk && skOld) begin
      if (drv) sh <= sh << 1;
      else if (cnt == 3 + ab && sr[ab+1 -: 2] == 2'h2) begin
        sh <= {1'b0, mem[sr[7:0] & amask]};
        drv <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> verif/tb.sv
// self-checking bench for the eeprom access and cmos lock block
`include "secl_defs.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] RLK = `SECL_IDX_RAM_LOCK, ELK = `SECL_IDX_EE_LOCK, PTR = `SECL_IDX_PTR;
  localparam logic [7:0] WB = `SECL_IDX_WBYTE, WS = `SECL_IDX_WPROG, RB = `SECL_IDX_RBYTE;
  localparam logic [7:0] RS = `SECL_IDX_RSTAT, IS = `SECL_IDX_IRQ_STAT, IM = `SECL_IDX_IRQ_MASK;
  logic clock = 1'b0, reset_n = 1'b0, softReset = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [6:0] cmosIndex = 7'h00;
  logic [7:0] q;
  logic memWide = 1'b1;
  wire logic hrdy, hresp, irq, cmosWriteOk, eeDo;
  wire logic [31:0] hrdata;
  wire logic [7:0] cmosAddr;
  wire secl_pkg::secl_pins_t eePins;
  int n_mismatch = 0;
  int n_compared = 0;
  always #5 clock = ~clock;
  secl_top #(.SK_HALF(2), .WRITE_TMO(200)) i_dut (.clock(clock), .reset_n(reset_n),
    .softReset(softReset), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy), .hresp(hresp),
    .hrdata(hrdata), .irq(irq), .cmosIndex(cmosIndex), .cmosAddr(cmosAddr),
    .cmosWriteOk(cmosWriteOk), .eePins(eePins), .eeDo(eeDo));
  secl_eeprom_model i_mem (.clock(clock), .wide(memWide), .pins(eePins), .eeDo(eeDo));
  task test_done;
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // waits for hready sampled high at a rising edge
  task hwait;
    int t;
    t = 0;
    @(posedge clock);
    while (hrdy !== 1'b1) begin
      t++;
      if (t > 50) begin
        n_mismatch++;
        test_done;
      end
      @(posedge clock);
    end
  endtask
  // one single-word transfer, address phase then data phase
  task xfer(input logic w, input logic [7:0] idx, input logic [7:0] d);
    haddr <= {22'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    hwait;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    hwait;
    q = hrdata[7:0];
  endtask
  task rdchk(input logic [7:0] idx, input logic [7:0] exp);
    xfer(1'b0, idx, 8'h00);
    chk(q, exp);
  endtask
  task poll(input logic [7:0] idx, input logic [7:0] exp);
    int t;
    xfer(1'b0, idx, 8'h00);
    for (t = 0; t < 400 && q !== exp; t++) xfer(1'b0, idx, 8'h00);
    chk(q, exp);
    if (q !== exp) test_done;
  endtask
  initial begin
    repeat (16) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    rdchk(WS, 8'h03);
    chk({7'h0, hresp}, 8'h00);
    rdchk(PTR, 8'h00);
    rdchk(RLK, 8'h00);
    rdchk(8'hfb, 8'h00);
    xfer(1'b1, ELK, 8'h12);
    xfer(1'b1, ELK, 8'h10);
    rdchk(ELK, 8'h12);
    xfer(1'b1, IM, 8'h07);
    xfer(1'b1, WS, 8'h80);
    xfer(1'b1, PTR, 8'h41);
    rdchk(PTR, 8'h41);
    poll(WS, 8'h83);
    xfer(1'b1, WB, 8'h34);
    rdchk(WS, 8'h82);
    xfer(1'b1, WB, 8'h12);
    rdchk(WS, 8'h80);
    rdchk(PTR, 8'h42);
    chk({7'h0, irq}, 8'h00);
    poll(WS, 8'h83);
    rdchk(IS, 8'h01);
    chk({7'h0, irq}, 8'h01);
    xfer(1'b1, IM, 8'h06);
    rdchk(IS, 8'h01);
    chk({7'h0, irq}, 8'h00);
    xfer(1'b1, IS, 8'h01);
    rdchk(IS, 8'h00);
    xfer(1'b1, WS, 8'h00);
    xfer(1'b1, PTR, 8'h41);
    poll(RS, 8'h01);
    chk({7'h0, irq}, 8'h01);
    rdchk(RB, 8'h34);
    rdchk(RB, 8'h12);
    rdchk(RS, 8'h00);
    rdchk(RB, 8'h00);
    rdchk(PTR, 8'h42);
    poll(RS, 8'h01);
    xfer(1'b1, IS, 8'h07);
    xfer(1'b1, ELK, 8'h16);
    xfer(1'b1, WS, 8'h80);
    xfer(1'b1, PTR, 8'h41);
    poll(WS, 8'h83);
    xfer(1'b1, WB, 8'hef);
    xfer(1'b1, WB, 8'hbe);
    poll(WS, 8'h83);
    rdchk(IS, 8'h04);
    xfer(1'b1, WS, 8'h00);
    xfer(1'b1, PTR, 8'h41);
    poll(RS, 8'h01);
    rdchk(RB, 8'h34);
    memWide <= 1'b0;
    xfer(1'b1, ELK, 8'h00);
    rdchk(ELK, 8'h06);
    xfer(1'b1, WS, 8'h80);
    xfer(1'b1, PTR, 8'h05);
    poll(WS, 8'h83);
    xfer(1'b1, WB, 8'h78);
    xfer(1'b1, WB, 8'h56);
    poll(WS, 8'h83);
    xfer(1'b1, WS, 8'h00);
    xfer(1'b1, PTR, 8'h05);
    poll(RS, 8'h01);
    rdchk(RB, 8'h78);
    rdchk(RB, 8'h56);
    cmosIndex <= 7'h05;
    xfer(1'b1, RLK, 8'h81);
    rdchk(RLK, 8'h81);
    chk(cmosAddr, 8'h85);
    chk({7'h0, cmosWriteOk}, 8'h00);
    cmosIndex <= 7'h65;
    xfer(1'b1, RLK, 8'h00);
    rdchk(RLK, 8'h01);
    chk(cmosAddr, 8'h65);
    xfer(1'b1, RLK, 8'h80);
    rdchk(RLK, 8'h81);
    chk({cmosAddr[7], 6'h0, cmosWriteOk}, 8'h81);
    softReset <= 1'b1;
    @(posedge clock);
    softReset <= 1'b0;
    rdchk(PTR, 8'h00);
    rdchk(WS, 8'h03);
    test_done;
  end
endmodule
`default_nettype wire
